// >>> hdl/temp_sensor_config_hysteresis_field_shutdown.sv
// configuration register, trip limits, hysteresis and alarm pin
// What this block does
// - configuration is a 16-bit read/write register at pointer 01h
// - bits 15:11 are reserved, read as zero; host keeps them zero
// - bits 10:9 pick hysteresis: none, 1.5, 3.0 or 6.0 degrees
// - the same hysteresis applies to upper, lower and critical limits
// - hysteresis only on falling temperature; upper and critical alarms set on crossing, lower alarm below limit minus hysteresis
// - a tripped upper or critical alarm clears only below limit minus hysteresis; a lower alarm clears above the lower limit
// - temperature bit 14 marks above upper limit, held with hysteresis
// - the alarm pin uses the same hysteresis
// - either lock bit blocks writes to hysteresis and shutdown
// - bit 8 high disables the sensor, low converts continuously
// - in shutdown no temperature updates and no alarm events
// - entering shutdown releases the alarm pin undriven
// - host writes the 8-bit pointer first, then reads or writes data
// - critical lock stays set until power-on reset
// - window lock makes upper and lower trip registers read-only
`timescale 1ns/1ps
module temp_sensor_config_hysteresis_field_shutdown #(
  parameter int TW = tsense_pkg::TEMP_W          // temperature word width
) (
  input  wire logic          core_clk,   // system clock, 125 MHz
  input  wire logic          rst,        // synchronous power-on reset
  input  wire logic          scl_in,     // serial clock pin
  input  wire logic          sda_in,     // serial data pin level
  output logic               sda_out_q,  // data drive level, always low
  output logic               sda_oe_q,   // data pin enable
  input  wire logic [2:0]    addr_pins,  // slave address pins
  input  wire logic [TW-1:0] temp_in,    // converter result, signed
  input  wire logic          temp_valid, // converter result strobe
  output logic               conv_en_q,  // converter run enable
  output logic               alarm_out_q, // alarm pin drive level
  output logic               alarm_oe_q  // alarm pin enable
);

  localparam int NB = 3;  // boundaries: 0 upper, 1 lower, 2 critical

  tsense_pkg::config_t  cfg_q;
  tsense_pkg::rx_byte_t rx;
  tsense_pkg::config_t  wcfg;
  logic [7:0]           ptr_q, msb_q;
  logic [15:0]          trip_q [NB];
  logic [TW-1:0]        temp_q;
  logic [NB-1:0]        above_q;
  logic                 cond_prev_q, irq_q, clear_q;
  logic [15:0]          tx_word, wdata;
  logic                 wr_word, any_lock, cond, asserted;
  logic [TW-1:0]        hysteresis_field;
  logic                 slave_oe;

  // ****************************************************************
  // serial port
  // ****************************************************************
  two_wire_slave u_slave (
    .core_clk  (core_clk),
    .rst       (rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .addr_pins (addr_pins),
    .tx_word   (tx_word),
    .rx_q      (rx),
    .sda_oe_q  (slave_oe)
  );

  assign sda_oe_q = slave_oe;
  assign wdata    = {msb_q, rx.data};
  assign wcfg     = wdata;
  assign wr_word  = rx.valid && rx.index == 2'h2;
  assign any_lock = cfg_q.critical_limit_lock | cfg_q.alarm_window_lock;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_q     <= tsense_pkg::PTR_RESET;
      msb_q     <= 8'h00;
      sda_out_q <= 1'b0;
    end else if (rx.valid) begin
      if (rx.index == 2'h0)
        ptr_q <= rx.data;
      if (rx.index == 2'h1)
        msb_q <= rx.data;
    end
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q   <= tsense_pkg::CONFIG_RESET;
      clear_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (wr_word && ptr_q == tsense_pkg::PTR_CONFIG) begin
        // locks only ever set; a write of zero cannot release them
        cfg_q.critical_limit_lock <= cfg_q.critical_limit_lock
                                     | wcfg.critical_limit_lock;
        cfg_q.alarm_window_lock   <= cfg_q.alarm_window_lock
                                     | wcfg.alarm_window_lock;
        clear_q                   <= wcfg.alarm_clear_strobe;
        if (!any_lock) begin
          cfg_q.hysteresis_select   <= wcfg.hysteresis_select;
          cfg_q.sensor_power_down   <= wcfg.sensor_power_down;
          cfg_q.alarm_output_enable <= wcfg.alarm_output_enable;
          cfg_q.alarm_polarity      <= wcfg.alarm_polarity;
          cfg_q.alarm_output_mode   <= wcfg.alarm_output_mode;
        end
        if (!cfg_q.alarm_window_lock)
          cfg_q.critical_only_alarm <= wcfg.critical_only_alarm;
      end
      cfg_q.alarm_asserted_flag <= asserted;
    end
  end

  // ****************************************************************
  // trip limit registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NB; i++)
        trip_q[i] <= tsense_pkg::TRIP_RESET;
    end else if (wr_word) begin
      if (ptr_q == tsense_pkg::PTR_UPPER && !cfg_q.alarm_window_lock)
        trip_q[0] <= wdata & tsense_pkg::TRIP_MASK;
      if (ptr_q == tsense_pkg::PTR_LOWER && !cfg_q.alarm_window_lock)
        trip_q[1] <= wdata & tsense_pkg::TRIP_MASK;
      if (ptr_q == tsense_pkg::PTR_CRIT && !cfg_q.critical_limit_lock)
        trip_q[2] <= wdata & tsense_pkg::TRIP_MASK;
    end
  end

  // ****************************************************************
  // temperature and boundary comparison with hysteresis
  // ****************************************************************
  always_comb begin
    case (cfg_q.hysteresis_select)
      tsense_pkg::HYSTERESIS_FIELD_1P5: hysteresis_field = TW'(tsense_pkg::HYSTERESIS_FIELD_1P5_STEPS);
      tsense_pkg::HYSTERESIS_FIELD_3P0: hysteresis_field = TW'(tsense_pkg::HYSTERESIS_FIELD_3P0_STEPS);
      tsense_pkg::HYSTERESIS_FIELD_6P0: hysteresis_field = TW'(tsense_pkg::HYSTERESIS_FIELD_6P0_STEPS);
      default:              hysteresis_field = TW'(tsense_pkg::HYSTERESIS_FIELD_NONE_STEPS);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst)
      temp_q <= TW'(tsense_pkg::TEMP_RESET);
    else if (temp_valid && !cfg_q.sensor_power_down)
      temp_q <= temp_in;
  end

  // each boundary keeps an "above" state; lower alarm is its inverse
  for (genvar g = 0; g < NB; g++) begin : g_bound
    logic signed [TW:0] t_s, lim_s, low_s;
    assign t_s   = {temp_in[TW-1], temp_in};
    assign lim_s = {trip_q[g][TW-1], trip_q[g][TW-1:0]};
    assign low_s = lim_s - {1'b0, hysteresis_field};
    always_ff @(posedge core_clk) begin
      if (rst)
        above_q[g] <= (g == 1); // lower starts satisfied, no alarm
      else if (temp_valid && !cfg_q.sensor_power_down) begin
        if (t_s > lim_s)
          above_q[g] <= 1'b1;
        else if (t_s < low_s)
          above_q[g] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // alarm pin
  // ****************************************************************
  assign cond = cfg_q.critical_only_alarm ? above_q[2]
              : (above_q[0] | above_q[2] | ~above_q[1]);
  assign asserted = cfg_q.alarm_output_enable & ~cfg_q.sensor_power_down
                  & (cfg_q.alarm_output_mode ? irq_q : cond);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cond_prev_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      cond_prev_q <= cond;
      // a new event in the clearing cycle wins over the clear
      if (cond && !cond_prev_q && !cfg_q.sensor_power_down)
        irq_q <= 1'b1;
      else if (clear_q)
        irq_q <= 1'b0;
    end
  end

  // open drain: only ever pulls low; active-high idles driven low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_oe_q  <= 1'b0;
      alarm_out_q <= 1'b0;
      conv_en_q   <= 1'b0;
    end else begin
      alarm_oe_q  <= ~cfg_q.sensor_power_down
                     & (asserted ^ cfg_q.alarm_polarity);
      alarm_out_q <= 1'b0;
      conv_en_q   <= ~cfg_q.sensor_power_down;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    case (ptr_q)
      tsense_pkg::PTR_CONFIG: begin
        tx_word        = cfg_q;
        tx_word[15:11] = 5'h00;
        tx_word[5]     = 1'b0;
      end
      tsense_pkg::PTR_UPPER: tx_word = trip_q[0];
      tsense_pkg::PTR_LOWER: tx_word = trip_q[1];
      tsense_pkg::PTR_CRIT:  tx_word = trip_q[2];
      tsense_pkg::PTR_TEMP: begin
        tx_word = 16'h0000;
        tx_word[TW-1:0] = temp_q;
        tx_word[tsense_pkg::TEMP_CRIT_BIT]  = above_q[2];
        tx_word[tsense_pkg::TEMP_UPPER_BIT] = above_q[0];
        tx_word[tsense_pkg::TEMP_LOWER_BIT] = ~above_q[1];
      end
      default: tx_word = 16'h0000;
    endcase
  end

endmodule // temp_sensor_config_hysteresis_field_shutdown

// >>> hdl/two_wire_slave.sv
// two-wire serial slave: byte framing, addressing and acknowledge
`timescale 1ns/1ps
module two_wire_slave (
  input  wire logic              core_clk,  // system clock
  input  wire logic              rst,       // synchronous reset
  input  wire logic              scl_in,    // serial clock pin
  input  wire logic              sda_in,    // serial data pin level
  input  wire logic [2:0]        addr_pins, // address select pins
  input  wire logic [15:0]       tx_word,   // word of selected register
  output tsense_pkg::rx_byte_t   rx_q,      // received byte strobe
  output logic                   sda_oe_q   // high pulls data line low
);

  typedef enum {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WR,
                ST_READ, ST_MACK} state_t;

  state_t      state_q;
  logic [1:0]  scl_s_q, sda_s_q;
  logic        scl_d_q, sda_d_q;
  logic [2:0]  apin1_q, apin2_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        rw_q, lsb_sel_q;
  logic [15:0] word_q;
  logic        scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0]  tx_byte;

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    scl_s_q <= {scl_s_q[0], scl_in};
    sda_s_q <= {sda_s_q[0], sda_in};
    apin1_q <= addr_pins;
    apin2_q <= apin1_q;
    scl_d_q <= scl_s_q[1];
    sda_d_q <= sda_s_q[1];
  end

  assign scl_rise   = scl_s_q[1] & ~scl_d_q;
  assign scl_fall   = ~scl_s_q[1] & scl_d_q;
  assign start_cond = scl_s_q[1] & scl_d_q & sda_d_q & ~sda_s_q[1];
  assign stop_cond  = scl_s_q[1] & scl_d_q & ~sda_d_q & sda_s_q[1];
  assign tx_byte    = lsb_sel_q ? word_q[7:0] : word_q[15:8];

  // ****************************************************************
  // framing state machine
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      lsb_sel_q <= 1'b0;
      word_q    <= 16'h0000;
      sda_oe_q  <= 1'b0;
      rx_q      <= '0;
    end else begin
      rx_q.valid <= 1'b0;
      if (start_cond) begin
        state_q    <= ST_ADDR;
        cnt_q      <= 4'h0;
        sda_oe_q   <= 1'b0;
        rx_q.index <= 2'h0;
      end else if (stop_cond) begin
        state_q  <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_WRITE: begin
            sh_q  <= {sh_q[6:0], sda_s_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end
          ST_READ: cnt_q <= cnt_q + 4'h1;
          ST_MACK: if (sda_s_q[1]) state_q <= ST_IDLE;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: if (cnt_q == 4'h8) begin
            if (sh_q[7:1] == {tsense_pkg::SLAVE_ADDR_BASE, apin2_q}) begin
              state_q  <= ST_ACK_ADDR;
              rw_q     <= sh_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_WRITE: if (cnt_q == 4'h8) begin
            // every byte is acknowledged, locked fields included
            state_q   <= ST_ACK_WR;
            sda_oe_q  <= 1'b1;
            rx_q.valid <= 1'b1;
            rx_q.data <= sh_q;
          end
          ST_ACK_ADDR, ST_ACK_WR: begin
            cnt_q <= 4'h0;
            if (state_q == ST_ACK_WR && rx_q.index != 2'h3)
              rx_q.index <= rx_q.index + 2'h1;
            if (state_q == ST_ACK_ADDR && rw_q) begin
              // word is frozen here so both bytes come from one value
              state_q   <= ST_READ;
              word_q    <= tx_word;
              lsb_sel_q <= 1'b0;
              sda_oe_q  <= ~tx_word[15];
            end else begin
              state_q  <= ST_WRITE;
              sda_oe_q <= 1'b0;
            end
          end
          ST_READ: begin
            if (cnt_q == 4'h8) begin
              state_q  <= ST_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= ~tx_byte[~cnt_q[2:0]];
            end
          end
          ST_MACK: begin
            state_q   <= ST_READ;
            cnt_q     <= 4'h0;
            lsb_sel_q <= ~lsb_sel_q;
            sda_oe_q  <= lsb_sel_q ? ~word_q[15] : ~word_q[7];
          end
          default: ;
        endcase
      end
    end
  end

endmodule // two_wire_slave

// >>> shared/tsense_pkg.sv
// shared constants and carriers for the temperature sensor register bank
package tsense_pkg;

  // ****************************************************************
  // register pointer values
  // ****************************************************************
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [7:0]  PTR_CONFIG   = 8'h01;
  localparam logic [7:0]  PTR_UPPER    = 8'h02;
  localparam logic [7:0]  PTR_LOWER    = 8'h03;
  localparam logic [7:0]  PTR_CRIT     = 8'h04;
  localparam logic [7:0]  PTR_TEMP     = 8'h05;

  // ****************************************************************
  // reset values and field layouts
  // ****************************************************************
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] TRIP_RESET   = 16'h0000;
  localparam logic [15:0] TRIP_MASK    = 16'h1ffc;
  localparam int          TEMP_W       = 13;
  localparam logic [12:0] TEMP_RESET   = 13'h0000;
  localparam int          TEMP_CRIT_BIT  = 15;
  localparam int          TEMP_UPPER_BIT = 14;
  localparam int          TEMP_LOWER_BIT = 13;
  localparam logic [3:0]  SLAVE_ADDR_BASE = 4'h3;

  // hysteresis amounts in 1/16 degree steps of the temperature word
  localparam logic [12:0] HYSTERESIS_FIELD_NONE_STEPS = 13'h0000;
  localparam logic [12:0] HYSTERESIS_FIELD_1P5_STEPS  = 13'h0018;
  localparam logic [12:0] HYSTERESIS_FIELD_3P0_STEPS  = 13'h0030;
  localparam logic [12:0] HYSTERESIS_FIELD_6P0_STEPS  = 13'h0060;

  typedef enum logic [1:0] {
    HYSTERESIS_FIELD_NONE, HYSTERESIS_FIELD_1P5, HYSTERESIS_FIELD_3P0, HYSTERESIS_FIELD_6P0
  } hysteresis_field_sel_t;

  typedef struct packed {
    logic [4:0] reserved_bits;
    hysteresis_field_sel_t  hysteresis_select;
    logic       sensor_power_down;
    logic       critical_limit_lock;
    logic       alarm_window_lock;
    logic       alarm_clear_strobe;
    logic       alarm_asserted_flag;
    logic       alarm_output_enable;
    logic       critical_only_alarm;
    logic       alarm_polarity;
    logic       alarm_output_mode;
  } config_t;

  // one received byte: index 0 is the pointer, 1 and 2 the data word
  typedef struct packed {
    logic       valid;
    logic [1:0] index;
    logic [7:0] data;
  } rx_byte_t;

endpackage

// >>> verif/i2c_host_model.sv
// two-wire bus master model driving the sensor's serial pins
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic core_clk, // system clock, paces the bus
  input  wire logic sda_line, // resolved data wire
  output logic      scl,      // serial clock, stands high when idle
  output logic      sda_drv   // data drive, 1 releases to pull-up
);
  logic nack_q; // a byte went unacknowledged in the last write
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nack_q = 1'b0;
  end
  // 4 low + 4 high cycles gives the 64 ns bit period
  task automatic clk_bit(input logic b, output logic s);
    @(negedge core_clk);
    sda_drv = b;
    repeat (3) @(negedge core_clk);
    scl = 1'b1;
    repeat (4) @(negedge core_clk);
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    @(negedge core_clk);
    sda_drv = 1'b0;
    repeat (4) @(negedge core_clk);
    scl = 1'b0;
  endtask
  // extra low time lets the device drop its acknowledge first
  task automatic stop();
    @(negedge core_clk);
    sda_drv = 1'b0;
    repeat (4) @(negedge core_clk);
    scl = 1'b1;
    repeat (4) @(negedge core_clk);
    sda_drv = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic tx_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], a);
    clk_bit(1'b1, a);
    nack_q = nack_q | a;
  endtask
  task automatic rx_byte(input logic last, output logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, a);
      b[i] = a;
    end
    clk_bit(last, a);
  endtask
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] w);
    nack_q = 1'b0;
    start();
    tx_byte(8'h30);
    tx_byte(ptr);
    tx_byte(w[15:8]);
    tx_byte(w[7:0]);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] w);
    start();
    tx_byte(8'h30);
    tx_byte(ptr);
    stop();
    start();
    tx_byte(8'h31);
    rx_byte(1'b0, w[15:8]);
    rx_byte(1'b1, w[7:0]);
    stop();
  endtask
endmodule // i2c_host_model

// >>> verif/tb.sv
// self-checking bench for the sensor configuration register bank
`timescale 1ns/1ps
module tb;
  localparam int TW = tsense_pkg::TEMP_W;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic          scl_in;
  logic          host_sda;
  logic          sda_in;
  logic          sda_out_q;
  logic          sda_oe_q;
  logic [TW-1:0] temp_in = 13'h0000;
  logic          temp_valid = 1'b0;
  logic          conv_en_q;
  logic          alarm_out_q;
  logic          alarm_oe_q;
  int            err_count = 0;
  int            tests_run = 0;
  always #4 core_clk = ~core_clk;
  // open-drain data wire with pull-up
  assign sda_in = host_sda & ~sda_oe_q;
  temp_sensor_config_hysteresis_field_shutdown #(.TW(TW))
    temp_sensor_config_hysteresis_field_shutdown_inst (.core_clk(core_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .addr_pins(3'b000), .temp_in(temp_in),
    .temp_valid(temp_valid), .conv_en_q(conv_en_q),
    .alarm_out_q(alarm_out_q), .alarm_oe_q(alarm_oe_q));
  i2c_host_model i2c_host_model_inst (.core_clk(core_clk),
    .sda_line(sda_in), .scl(scl_in), .sda_drv(host_sda));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] w;
    i2c_host_model_inst.read_reg(ptr, w);
    chk16(w, exp);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    i2c_host_model_inst.write_reg(ptr, w);
  endtask
  task automatic push_temp(input logic [12:0] t);
    @(negedge core_clk);
    temp_in = t;
    temp_valid = 1'b1;
    @(negedge core_clk);
    temp_valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(tsense_pkg::PTR_CONFIG, tsense_pkg::CONFIG_RESET);
    rd(8'h30, 16'h0000);
    chk1(conv_en_q, 1'b1);
  endtask
  task automatic t_hysteresis_field_codes();
    for (int h = 0; h < 4; h++) begin
      wr(tsense_pkg::PTR_CONFIG, {5'h00, h[1:0], 9'h000});
      rd(tsense_pkg::PTR_CONFIG, {5'h00, h[1:0], 9'h000});
    end
    // the host keeps the reserved bits zero; they must still read zero
    wr(tsense_pkg::PTR_CONFIG, 16'h0200);
    rd(tsense_pkg::PTR_CONFIG, 16'h0200);
  endtask
  task automatic t_hysteresis_field_limits();
    logic [12:0] tv [4] = '{13'h0550, 13'h0551, 13'h0538, 13'h0537};
    logic        fl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr(tsense_pkg::PTR_UPPER, 16'h0550);
    wr(tsense_pkg::PTR_CRIT, 16'h0550);
    for (int i = 0; i < 4; i++) begin
      push_temp(tv[i]);
      rd(tsense_pkg::PTR_TEMP, {fl[i], fl[i], 1'b0, tv[i]});
    end
  endtask
  task automatic t_alarm_shdn();
    wr(tsense_pkg::PTR_CONFIG, 16'h0208);
    push_temp(13'h0551);
    chk1(alarm_oe_q, 1'b1);
    push_temp(13'h0540);
    chk1(alarm_oe_q, 1'b1);
    wr(tsense_pkg::PTR_CONFIG, 16'h0308);
    repeat (3) @(negedge core_clk);
    chk1(alarm_oe_q, 1'b0);
    chk1(conv_en_q, 1'b0);
    push_temp(13'h0100);
    rd(tsense_pkg::PTR_TEMP, 16'hc540);
    chk1(alarm_oe_q, 1'b0);
  endtask
  task automatic t_alarm_irq();
    // interrupt mode: a new crossing after the clear sets the pin; flipping the polarity releases it while the flag stays set
    wr(tsense_pkg::PTR_CONFIG, 16'h0229);
    repeat (3) @(negedge core_clk);
    chk1(alarm_oe_q, 1'b0);
    push_temp(13'h0500);
    chk1(alarm_oe_q, 1'b0);
    push_temp(13'h0551);
    chk1(alarm_oe_q, 1'b1);
    wr(tsense_pkg::PTR_CONFIG, 16'h020b);
    repeat (3) @(negedge core_clk);
    chk1(alarm_oe_q, 1'b0);
    rd(tsense_pkg::PTR_CONFIG, 16'h021b);
  endtask
  task automatic t_locks();
    do_reset();
    rd(tsense_pkg::PTR_CONFIG, 16'h0000);
    wr(tsense_pkg::PTR_CONFIG, 16'h0280);
    wr(tsense_pkg::PTR_CONFIG, 16'h0500);
    chk1(i2c_host_model_inst.nack_q, 1'b0);
    rd(tsense_pkg::PTR_CONFIG, 16'h0280);
    chk1(conv_en_q, 1'b1);
    do_reset();
    wr(tsense_pkg::PTR_CONFIG, 16'h0040);
    wr(tsense_pkg::PTR_UPPER, 16'h0100);
    rd(tsense_pkg::PTR_UPPER, 16'h0000);
    wr(tsense_pkg::PTR_CONFIG, 16'h0340);
    rd(tsense_pkg::PTR_CONFIG, 16'h0040);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    $display("BAD %0t run did not finish in time", $time);
    summarize();
  end
  initial begin
    do_reset();
    t_reset();
    t_hysteresis_field_codes();
    t_hysteresis_field_limits();
    t_alarm_shdn();
    t_alarm_irq();
    t_locks();
    summarize();
  end
endmodule // tb

// >>> verif/tsense_checker.sv
// concurrent checks on the sensor register bank pins
`timescale 1ns/1ps
module tsense_checker #(
  parameter int TW = tsense_pkg::TEMP_W // temperature word width
) (
  input wire logic          core_clk,    // system clock
  input wire logic          rst,         // synchronous reset
  input wire logic          scl_in,      // serial clock pin
  input wire logic          sda_in,      // data wire level
  input wire logic          sda_out_q,   // data drive level
  input wire logic          sda_oe_q,    // data pin enable
  input wire logic [2:0]    addr_pins,   // address pins
  input wire logic [TW-1:0] temp_in,     // converter result
  input wire logic          temp_valid,  // converter strobe
  input wire logic          conv_en_q,   // converter run enable
  input wire logic          alarm_out_q, // alarm drive level
  input wire logic          alarm_oe_q   // alarm pin enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // reset and shutdown
  // ****************************************************************
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !sda_oe_q && !alarm_oe_q && !conv_en_q)
    else $error("outputs active after reset");
  a_conv_resume: assert property ($fell(rst) |-> ##[0:1] conv_en_q)
    else $error("converter idle after reset");
  // the word commits a few cycles after the clock falls, so look back
  a_shdn_by_bus: assert property (
    $fell(conv_en_q) |-> !$past(scl_in, 3))
    else $error("shutdown outside a bus write");
  a_shdn_release: assert property (
    $fell(conv_en_q) |-> ##[0:2] !alarm_oe_q)
    else $error("alarm pin held in shutdown");
  a_shdn_quiet: assert property (
    (!conv_en_q) [*3] |-> !alarm_oe_q)
    else $error("alarm raised in shutdown");
  a_drive_low: assert property (
    sda_out_q == 1'b0 && alarm_out_q == 1'b0)
    else $error("open drain pin driven high");
  // ****************************************************************
  // serial data timing
  // ****************************************************************
  a_sda_low_only: assert property ($changed(sda_oe_q) |-> !scl_in)
    else $error("data changed while clock high");
  a_ack_stands: assert property ($rose(sda_oe_q) |-> sda_oe_q [*6])
    else $error("data drive too short");
endmodule // tsense_checker

bind temp_sensor_config_hysteresis_field_shutdown tsense_checker #(.TW(TW))
  tsense_checker_inst (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
  .addr_pins(addr_pins), .temp_in(temp_in), .temp_valid(temp_valid),
  .conv_en_q(conv_en_q), .alarm_out_q(alarm_out_q),
  .alarm_oe_q(alarm_oe_q));
